// File: hw/dua_regs.sv
// register bank, baud generator and host handshakes of the dual uart
`timescale 1ns/1ns
module dua_regs
   import dua_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // host parallel bus
   input  wire logic [CHANNELS-1:0]   chip_sel_n,
   input  wire logic                  read_not_write,
   input  wire logic [2:0]            addr,
   input  wire logic [7:0]            data_in,
   output logic      [7:0]            data_out,
   output logic                       data_oe,
   // per channel fifo side
   input  wire logic [CHANNELS-1:0]   tx_fifo_ready,
   input  wire logic [CHANNELS-1:0]   rx_fifo_ready,
   input  wire logic [CHANNELS-1:0]   rx_stop_done,
   input  wire logic [CHANNELS*8-1:0] rx_data,
   output logic      [CHANNELS-1:0]   tx_load,
   output logic      [7:0]            tx_data,
   output logic      [CHANNELS-1:0]   rx_read,
   output logic      [CHANNELS-1:0]   tx_start,
   output logic      [CHANNELS-1:0]   baud_tick,
   output logic      [CHANNELS*5-1:0] tx_trigger,
   output logic      [CHANNELS*5-1:0] rx_trigger,
   // host handshake pins; the ready outputs are active low, rx_irq is active high
   output logic      [CHANNELS-1:0]   rx_irq,
   output logic      [CHANNELS-1:0]   receive_ready_out_n,
   output logic      [CHANNELS-1:0]   transmit_ready_out_n
);

   // banked registers, one copy per channel
   logic [7:0] div_low_q     [CHANNELS];
   logic [7:0] div_high_q    [CHANNELS];
   logic [7:0] feature_q     [CHANNELS];
   logic [7:0] line_ctrl_q   [CHANNELS];
   logic [7:0] modem_ctrl_q  [CHANNELS];
   logic [7:0] fifo_ctrl_q   [CHANNELS];
   logic [7:0] resume_one_q  [CHANNELS];
   logic [7:0] resume_two_q  [CHANNELS];
   logic [7:0] stop_one_q    [CHANNELS];
   logic [7:0] stop_two_q    [CHANNELS];
   logic [7:0] threshold_q   [CHANNELS];
   logic [7:0] trigger_q     [CHANNELS];

   // bus front end
   logic [CHANNELS-1:0] sel_prev_q;
   logic [CHANNELS-1:0] access_go;
   logic [7:0]          data_out_q;
   logic                data_oe_q;
   logic [7:0]          tx_data_q;
   logic [7:0]          read_mux     [CHANNELS];
   logic [7:0]          ready_status;
   logic [7:0]          selected_rd;

   // per channel outputs
   logic [CHANNELS-1:0]   tx_load_q;
   logic [CHANNELS-1:0]   rx_read_q;
   logic [CHANNELS-1:0]   tx_start_q;
   logic [CHANNELS-1:0]   baud_tick_q;
   logic [CHANNELS-1:0]   rx_irq_q;
   logic [CHANNELS-1:0]   rx_ready_n_q;
   logic [CHANNELS-1:0]   tx_ready_n_q;
   logic [CHANNELS*5-1:0] tx_trig_q;
   logic [CHANNELS*5-1:0] rx_trig_q;

   // shared fifo-ready status; reserved bits tie to zero
   assign ready_status = {2'b00, rx_fifo_ready[1:0], 2'b00, tx_fifo_ready[1:0]};

   // a new access starts when a chip select falls; inputs are synchronous
   // a select held low covers one access only, so the host raises it between accesses
   assign access_go = sel_prev_q & ~chip_sel_n;

   // readback of whichever channel is selected; channel a wins on overlap
   assign selected_rd = !chip_sel_n[0] ? read_mux[0] : read_mux[CHANNELS-1];

   // bus front end flops
   // data_oe lags the select by one edge; the host samples read data one edge later too
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sel_prev_q <= '1;
         data_out_q <= RESET_ZERO;
         data_oe_q  <= 1'b0;
         tx_data_q  <= RESET_ZERO;
      end else begin
         sel_prev_q <= chip_sel_n;
         data_oe_q  <= read_not_write && (chip_sel_n != '1);
         data_out_q <= selected_rd;  // refreshed every cycle so status is live
         if ((access_go != '0) && !read_not_write) begin
            tx_data_q <= data_in;
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
         // page decode; the magic value bfh also has bit 7 set, so it wins first
         logic          bank_flow;
         logic          bank_div;
         logic          enh_en;
         logic          tcr_open;
         logic          status_open;
         logic          wr;
         logic          rd;
         logic          wr_data;
         logic [7:0]    mux_d;
         logic [15:0]   divisor;
         logic [1:0]    presc_q;
         logic          presc_tick;
         logic [15:0]   baud_cnt_q;
         logic [4:0]    tx_cnt_q;
         dua_tx_state_t tx_state_q;
         dua_tx_state_t tx_state_d;

         assign bank_flow   = (line_ctrl_q[ch] == LINE_CTRL_BANK_FLOW);
         assign bank_div    = line_ctrl_q[ch][LINE_CTRL_DIV_BIT] && !bank_flow;
         assign enh_en      = feature_q[ch][FEATURE_ENH_BIT];
         assign tcr_open    = enh_en && modem_ctrl_q[ch][MODEM_TCR_EN_BIT];
         assign status_open = modem_ctrl_q[ch][MODEM_STAT_EN_BIT] &&
                              !modem_ctrl_q[ch][MODEM_LOOP_BIT];
         assign wr          = access_go[ch] && !read_not_write;
         assign rd          = access_go[ch] && read_not_write;
         assign wr_data     = wr && !line_ctrl_q[ch][LINE_CTRL_DIV_BIT] && (addr == OFS_DATA);

         // readback mux for this channel's page
         always_comb begin
            mux_d = RESET_ZERO;
            if (addr == OFS_LINE_CTRL) begin
               mux_d = line_ctrl_q[ch];
            end else if (bank_flow) begin
               case (addr)
                  OFS_FEATURE:    mux_d = feature_q[ch];
                  OFS_RESUME_ONE: mux_d = resume_one_q[ch];
                  OFS_RESUME_TWO: mux_d = resume_two_q[ch];
                  OFS_STOP_ONE:   mux_d = stop_one_q[ch];
                  OFS_STOP_TWO:   mux_d = stop_two_q[ch];
                  default:        mux_d = RESET_ZERO;
               endcase
            end else if (bank_div && (addr == OFS_DIV_LOW)) begin
               mux_d = div_low_q[ch];
            end else if (bank_div && (addr == OFS_DIV_HIGH)) begin
               mux_d = div_high_q[ch];
            end else begin
               case (addr)
                  OFS_DATA:       mux_d = rx_data[ch*8 +: 8];
                  OFS_MODEM_CTRL: mux_d = modem_ctrl_q[ch];
                  OFS_THRESHOLD:  mux_d = tcr_open ? threshold_q[ch] : RESET_ZERO;
                  OFS_READY_STAT: mux_d = status_open ? ready_status :
                                          (tcr_open ? trigger_q[ch] : RESET_ZERO);
                  default:        mux_d = RESET_ZERO;
               endcase
            end
         end
         assign read_mux[ch] = mux_d;

         // register writes, decoded on the falling edge of this channel's select
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               div_low_q[ch]    <= RESET_ZERO;
               div_high_q[ch]   <= RESET_ZERO;
               feature_q[ch]    <= RESET_ZERO;
               line_ctrl_q[ch]  <= RESET_ZERO;
               modem_ctrl_q[ch] <= RESET_ZERO;
               fifo_ctrl_q[ch]  <= RESET_ZERO;
               resume_one_q[ch] <= RESET_ZERO;
               resume_two_q[ch] <= RESET_ZERO;
               stop_one_q[ch]   <= RESET_ZERO;
               stop_two_q[ch]   <= RESET_ZERO;
               threshold_q[ch]  <= RESET_ZERO;
               trigger_q[ch]    <= RESET_ZERO;
            end else if (wr) begin
               if (addr == OFS_LINE_CTRL) begin
                  line_ctrl_q[ch] <= data_in;
               end else if (bank_flow) begin
                  case (addr)
                     OFS_FEATURE:    feature_q[ch]    <= data_in;
                     OFS_RESUME_ONE: resume_one_q[ch] <= data_in;
                     OFS_RESUME_TWO: resume_two_q[ch] <= data_in;
                     OFS_STOP_ONE:   stop_one_q[ch]   <= data_in;
                     OFS_STOP_TWO:   stop_two_q[ch]   <= data_in;
                     default:        ;
                  endcase
               end else if (bank_div && (addr == OFS_DIV_LOW)) begin
                  div_low_q[ch] <= data_in;
               end else if (bank_div && (addr == OFS_DIV_HIGH)) begin
                  div_high_q[ch] <= data_in;
               end else if (!bank_div) begin
                  case (addr)
                     OFS_FIFO_CTRL: fifo_ctrl_q[ch] <= data_in;
                     OFS_MODEM_CTRL: begin
                        // upper modem bits, prescaler among them, are guarded
                        modem_ctrl_q[ch][MODEM_GUARD_LSB-1:0] <= data_in[MODEM_GUARD_LSB-1:0];
                        if (enh_en) begin
                           modem_ctrl_q[ch][7:MODEM_GUARD_LSB] <= data_in[7:MODEM_GUARD_LSB];
                        end
                     end
                     OFS_THRESHOLD: if (tcr_open) threshold_q[ch] <= data_in;
                     OFS_TRIGGER:   if (tcr_open) trigger_q[ch]   <= data_in;
                     default:       ;
                  endcase
               end
            end
         end

         // prescaler then 16-bit divisor; a zero divisor holds the baud clock still
         // a divisor lowered below the running count ends the period at once rather than wrapping
         assign divisor    = {div_high_q[ch], div_low_q[ch]};
         assign presc_tick = !modem_ctrl_q[ch][MODEM_PRESC_BIT] || (presc_q == PRESC_DIV4_LAST);
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               presc_q          <= 2'h0;
               baud_cnt_q       <= 16'h0000;
               baud_tick_q[ch]  <= 1'b0;
            end else begin
               presc_q         <= presc_tick ? 2'h0 : presc_q + 2'h1;
               baud_tick_q[ch] <= 1'b0;
               if (divisor == 16'h0000) begin
                  baud_cnt_q <= 16'h0000;
               end else if (presc_tick) begin
                  if (baud_cnt_q >= divisor - 16'h0001) begin
                     baud_cnt_q      <= 16'h0000;
                     baud_tick_q[ch] <= 1'b1;
                  end else begin
                     baud_cnt_q <= baud_cnt_q + 16'h0001;
                  end
               end
            end
         end

         // transmit start sequencer: waits a fixed number of baud periods
         always_comb begin
            tx_state_d = tx_state_q;
            case (tx_state_q)
               TX_IDLE:  if (wr_data) tx_state_d = TX_WAIT;
               TX_WAIT:  if (baud_tick_q[ch] && (tx_cnt_q == 5'(TX_START_DELAY_T - 1))) tx_state_d = TX_START;
               TX_START: tx_state_d = TX_IDLE;
               default:  tx_state_d = TX_IDLE;
            endcase
         end

         // a data write during the wait does not restart the count; tx_load still pulses
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               tx_state_q       <= TX_IDLE;
               tx_cnt_q         <= 5'h00;
               tx_start_q[ch]   <= 1'b0;
               tx_load_q[ch]    <= 1'b0;
               tx_ready_n_q[ch] <= 1'b1;
            end else begin
               tx_state_q     <= tx_state_d;
               tx_load_q[ch]  <= wr_data;
               tx_start_q[ch] <= (tx_state_d == TX_START);
               if (tx_state_q == TX_IDLE) begin
                  tx_cnt_q <= 5'h00;
               end else if (baud_tick_q[ch]) begin
                  tx_cnt_q <= tx_cnt_q + 5'h01;
               end
               // drops together with the start bit, well inside the limit
               if (tx_state_d == TX_START) begin
                  tx_ready_n_q[ch] <= 1'b1;
               end else begin
                  tx_ready_n_q[ch] <= !tx_fifo_ready[ch];
               end
            end
         end

         // receive flags: a stop bit in the read cycle wins over the clear
         // the clear comes from the registered read pulse, two edges after the access starts
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               rx_irq_q[ch]     <= 1'b0;
               rx_ready_n_q[ch] <= 1'b1;
               rx_read_q[ch]    <= 1'b0;
            end else begin
               rx_read_q[ch] <= rd && !line_ctrl_q[ch][LINE_CTRL_DIV_BIT] && (addr == OFS_DATA);
               if (rx_stop_done[ch]) begin
                  rx_irq_q[ch]     <= 1'b1;
                  rx_ready_n_q[ch] <= 1'b0;
               end else if (rx_read_q[ch]) begin
                  rx_irq_q[ch]     <= 1'b0;
                  rx_ready_n_q[ch] <= 1'b1;
               end
            end
         end

         // effective trigger levels: bit 4 flags fallback to fifo control selection
         // registered so a trigger write never glitches the levels seen downstream
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               tx_trig_q[ch*5 +: 5] <= 5'h10;
               rx_trig_q[ch*5 +: 5] <= 5'h10;
            end else begin
               tx_trig_q[ch*5 +: 5] <= (trigger_q[ch][3:0] == 4'h0) ?
                  {3'b100, fifo_ctrl_q[ch][FIFO_CTRL_TX_LSB +: 2]} : {1'b0, trigger_q[ch][3:0]};
               rx_trig_q[ch*5 +: 5] <= (trigger_q[ch][7:4] == 4'h0) ?
                  {3'b100, fifo_ctrl_q[ch][FIFO_CTRL_RX_LSB +: 2]} : {1'b0, trigger_q[ch][7:4]};
            end
         end
      end
   endgenerate

   // outputs straight from flops
   assign data_out             = data_out_q;
   assign data_oe              = data_oe_q;
   assign tx_data              = tx_data_q;
   assign tx_load              = tx_load_q;
   assign rx_read              = rx_read_q;
   assign tx_start             = tx_start_q;
   assign baud_tick            = baud_tick_q;
   assign tx_trigger           = tx_trig_q;
   assign rx_trigger           = rx_trig_q;
   assign rx_irq               = rx_irq_q;
   assign receive_ready_out_n  = rx_ready_n_q;
   assign transmit_ready_out_n = tx_ready_n_q;

endmodule

// File: hw/dua_pkg.sv
// constants shared by the dual uart register access block
package dua_pkg;
   // register offsets on the 3-bit address
   localparam logic [2:0] OFS_DATA       = 3'h0;
   localparam logic [2:0] OFS_DIV_LOW    = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH   = 3'h1;
   localparam logic [2:0] OFS_FEATURE    = 3'h2;
   localparam logic [2:0] OFS_FIFO_CTRL  = 3'h2;
   localparam logic [2:0] OFS_LINE_CTRL  = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
   localparam logic [2:0] OFS_RESUME_ONE = 3'h4;
   localparam logic [2:0] OFS_RESUME_TWO = 3'h5;
   localparam logic [2:0] OFS_STOP_ONE   = 3'h6;
   localparam logic [2:0] OFS_THRESHOLD  = 3'h6;
   localparam logic [2:0] OFS_STOP_TWO   = 3'h7;
   localparam logic [2:0] OFS_TRIGGER    = 3'h7;
   localparam logic [2:0] OFS_READY_STAT = 3'h7;
   // magic line-control values that page the banked registers
   localparam logic [7:0] LINE_CTRL_BANK_FLOW = 8'hbf;
   localparam int         LINE_CTRL_DIV_BIT   = 7;
   // field positions
   localparam int FEATURE_ENH_BIT   = 4;
   localparam int MODEM_STAT_EN_BIT = 2;
   localparam int MODEM_LOOP_BIT    = 4;
   localparam int MODEM_TCR_EN_BIT  = 6;
   localparam int MODEM_PRESC_BIT   = 7;
   localparam int MODEM_GUARD_LSB   = 5;
   localparam int READY_TX_LSB      = 0;
   localparam int READY_RX_LSB      = 4;
   localparam int FIFO_CTRL_RX_LSB  = 6;
   localparam int FIFO_CTRL_TX_LSB  = 4;
   // reset values
   localparam logic [7:0] RESET_ZERO = 8'h00;
   // prescaler and baud timing, in internal baud-clock periods
   localparam logic [1:0] PRESC_DIV4_LAST = 2'h3;
   localparam int TX_START_MIN_T   = 8;
   localparam int TX_START_MAX_T   = 24;
   localparam int TX_START_DELAY_T = (TX_START_MIN_T + TX_START_MAX_T) / 2;
   // transmit start sequencer, one bit changes per step except start back to idle, which changes two
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_WAIT  = 2'b01,
      TX_START = 2'b11
   } dua_tx_state_t;
endpackage

// File: test/dua_regs_asserts.sv
// port-level checks on the dual uart register block
`timescale 1ns/1ns
module dua_regs_asserts
   import dua_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   // clock and reset
   input wire logic                clk_sys,
   input wire logic                reset_n,
   // host bus
   input wire logic [CHANNELS-1:0] chip_sel_n,
   input wire logic                read_not_write,
   input wire logic [2:0]          addr,
   input wire logic                data_oe,
   // fifo side and handshakes
   input wire logic [CHANNELS-1:0] rx_stop_done,
   input wire logic [CHANNELS-1:0] tx_load,
   input wire logic [CHANNELS-1:0] rx_read,
   input wire logic [CHANNELS-1:0] tx_start,
   input wire logic [CHANNELS-1:0] baud_tick,
   input wire logic [CHANNELS-1:0] rx_irq,
   input wire logic [CHANNELS-1:0] receive_ready_out_n,
   input wire logic [CHANNELS-1:0] transmit_ready_out_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic       pend_q;
   logic [5:0] ticks_q;
   logic [3:0] rd_q;
   wire        rd0 = !chip_sel_n[0] && read_not_write && addr == 3'h0;
   wire        wr0 = !chip_sel_n[0] && !read_not_write && addr == 3'h0;
   // baud periods since a channel a load; saturates so a stuck sequencer still trips the bound
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pend_q  <= 1'b0;
         ticks_q <= 6'h00;
         rd_q    <= 4'h0;
      end else begin
         pend_q  <= tx_load[0] | (pend_q & ~tx_start[0]);
         ticks_q <= tx_load[0] ? 6'h00 : ticks_q + {5'h00, baud_tick[0] & pend_q & (ticks_q != 6'h3f)};
         rd_q    <= {rd_q[2:0], rd0};
      end
   end
   // both receive flags rise together one edge after the stop bit
   sequence s_flags_a;
      rx_irq[0] && !receive_ready_out_n[0];
   endsequence
   property p_irq_on_stop;
      rx_stop_done[0] |=> s_flags_a;
   endproperty
   property p_rdy_on_stop;
      rx_stop_done[1] |=> rx_irq[1] ##0 !receive_ready_out_n[1];
   endproperty
   property p_irq_clear;
      $fell(rx_irq[0]) |-> |rd_q;
   endproperty
   property p_rdy_clear;
      $rose(receive_ready_out_n[0]) |-> |rd_q;
   endproperty
   property p_transmit_ready_out_drop;
      $rose(tx_start[0]) |-> transmit_ready_out_n[0];
   endproperty
   property p_start_window;
      tx_start[0] |-> pend_q && ticks_q >= 6'd8 && ticks_q <= 6'd24;
   endproperty
   property p_start_bound;
      pend_q |-> ticks_q <= 6'd24;
   endproperty
   property p_load_cause;
      tx_load[0] |-> $past(wr0);
   endproperty
   property p_oe_idle;
      &chip_sel_n |=> !data_oe;
   endproperty
   property p_read_cause;
      rx_read[0] |-> $past(rd0);
   endproperty
   property p_oe_read;
      !chip_sel_n[0] && read_not_write |=> data_oe;
   endproperty
   a_irq_on_stop: assert property (p_irq_on_stop) else $error("receive flags late");
   a_rdy_on_stop: assert property (p_rdy_on_stop) else $error("channel b flags late");
   a_irq_clear: assert property (p_irq_clear) else $error("irq dropped without read");
   a_rdy_clear: assert property (p_rdy_clear) else $error("rx ready dropped without read");
   a_transmit_ready_out_drop: assert property (p_transmit_ready_out_drop) else $error("tx ready held at start");
   a_start_window: assert property (p_start_window) else $error("start bit outside window");
   a_start_bound: assert property (p_start_bound) else $error("start bit overdue");
   a_load_cause: assert property (p_load_cause) else $error("load without data write");
   a_oe_idle: assert property (p_oe_idle) else $error("bus driven while unselected");
   a_read_cause: assert property (p_read_cause) else $error("read pulse without data read");
   a_oe_read: assert property (p_oe_read) else $error("bus not driven during read");
endmodule
bind dua_regs dua_regs_asserts #(.CHANNELS(CHANNELS)) u_dua_regs_asserts (
   .clk_sys(clk_sys), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .read_not_write(read_not_write),
   .addr(addr), .data_oe(data_oe), .rx_stop_done(rx_stop_done), .tx_load(tx_load), .tx_start(tx_start),
   .rx_read(rx_read), .baud_tick(baud_tick), .rx_irq(rx_irq), .receive_ready_out_n(receive_ready_out_n),
   .transmit_ready_out_n(transmit_ready_out_n));

// File: test/dua_host_model.sv
// host processor model on the parallel register bus
`timescale 1ns/1ns
module dua_host_model (
   // clock
   input  wire logic       clk_sys,
   // bus to the device
   output logic      [1:0] chip_sel_n,
   output logic            read_not_write,
   output logic      [2:0] addr,
   output logic      [7:0] data_in,
   input  wire logic [7:0] data_out
);
   // selects idle high from time zero so reset always lands on a quiet bus
   initial begin
      chip_sel_n     = 2'b11;
      read_not_write = 1'b1;
      addr           = 3'h0;
      data_in        = 8'h00;
   end
   // one access; a read holds one edge more for the registered data
   task automatic access(input logic [1:0] s, input logic rnw, input logic [2:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk_sys);
      chip_sel_n     <= s;
      read_not_write <= rnw;
      addr           <= a;
      data_in        <= d;
      repeat (rnw ? 2 : 1) @(posedge clk_sys);
      q = data_out;
      chip_sel_n     <= 2'b11;
      addr           <= ~a;
      data_in        <= ~d;
      @(posedge clk_sys);
   endtask
endmodule

// File: test/tb.sv
// self-checking bench for the dual uart register block
`timescale 1ns/1ns
module tb;
   import dua_pkg::*;
   logic        clk_sys;
   logic        reset_n;
   logic [1:0]  chip_sel_n;
   logic        read_not_write;
   logic [2:0]  addr;
   logic [7:0]  data_in;
   logic [7:0]  data_out;
   logic [1:0]  tx_fifo_ready;
   logic [1:0]  rx_fifo_ready;
   logic [1:0]  rx_stop_done;
   logic [15:0] rx_data;
   logic [7:0]  tx_data;
   logic [1:0]  tx_start;
   logic [1:0]  baud_tick;
   logic [9:0]  tx_trigger;
   logic [9:0]  rx_trigger;
   logic [1:0]  rx_irq;
   logic [1:0]  receive_ready_out_n;
   logic [1:0]  transmit_ready_out_n;
   int          fail_count = 0;
   int          check_count = 0;
   dua_regs #(.CHANNELS(2)) u_dua_regs (
      .clk_sys(clk_sys), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .read_not_write(read_not_write),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(), .tx_fifo_ready(tx_fifo_ready),
      .rx_fifo_ready(rx_fifo_ready), .rx_stop_done(rx_stop_done), .rx_data(rx_data), .tx_load(),
      .tx_data(tx_data), .rx_read(), .tx_start(tx_start), .baud_tick(baud_tick), .tx_trigger(tx_trigger),
      .rx_trigger(rx_trigger), .rx_irq(rx_irq), .receive_ready_out_n(receive_ready_out_n),
      .transmit_ready_out_n(transmit_ready_out_n));
   dua_host_model u_dua_host_model (
      .clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .read_not_write(read_not_write), .addr(addr),
      .data_in(data_in), .data_out(data_out));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_dua_host_model.access(s, 1'b0, a, d, q);
   endtask
   task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
      u_dua_host_model.access(s, 1'b1, a, 8'h00, q);
      check(nm, {8'h00, e}, {8'h00, q});
   endtask
   // skips two ticks so a prescaler change has settled, then times one baud period
   task automatic tick_gap(input int exp, input string nm);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         @(posedge clk_sys);
         while (baud_tick[0] !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
         end
      end
      check(nm, 16'(exp), 16'(n + 1));
   endtask
   // enhanced modem bits refuse writes until the feature bit opens them, the threshold register until modem bit 6 is also set
   task automatic t_guard;
      wr(2'b10, 3'h4, 8'hc4);
      rd(2'b10, 3'h4, 8'h04, "modem_guarded");
      wr(2'b10, 3'h6, 8'h5a);
      rd(2'b10, 3'h6, 8'h00, "threshold_guarded");
      $display("test guard done");
   endtask
   task automatic t_banks;
      logic [2:0] pa [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
      wr(2'b10, 3'h3, 8'h80);
      wr(2'b10, 3'h1, 8'h01);
      rd(2'b10, 3'h1, 8'h01, "div_high");
      wr(2'b10, 3'h1, 8'h00);
      wr(2'b10, 3'h0, 8'h03);
      rd(2'b10, 3'h0, 8'h03, "div_low");
      wr(2'b10, 3'h3, LINE_CTRL_BANK_FLOW);
      wr(2'b01, 3'h3, LINE_CTRL_BANK_FLOW);
      foreach (pa[i]) wr(2'b10, pa[i], 8'h10 + 8'(i) * 8'h11);
      foreach (pa[i]) rd(2'b10, pa[i], 8'h10 + 8'(i) * 8'h11, "bank_a");
      foreach (pa[i]) rd(2'b01, pa[i], 8'h00, "bank_b");
      wr(2'b00, 3'h3, 8'h00);
      $display("test banks done");
   endtask
   task automatic t_flow;
      wr(2'b10, 3'h4, 8'h40);
      wr(2'b10, 3'h6, 8'h5a);
      wr(2'b10, 3'h7, 8'h30);
      wr(2'b10, 3'h2, 8'h20);
      rd(2'b10, 3'h6, 8'h5a, "threshold");
      rd(2'b10, 3'h7, 8'h30, "trigger");
      check("rx_trigger", 16'h0003, {11'h0, rx_trigger[4:0]});
      check("tx_trigger", 16'h0012, {11'h0, tx_trigger[4:0]});
      check("tx_trigger_b", 16'h0010, {11'h0, tx_trigger[9:5]});
      $display("test flow done");
   endtask
   task automatic t_status;
      @(posedge clk_sys);
      tx_fifo_ready <= 2'b01;
      rx_fifo_ready <= 2'b10;
      wr(2'b10, 3'h4, 8'h14);
      rd(2'b10, 3'h7, 8'h00, "loopback_hides");
      wr(2'b10, 3'h4, (8'h14 & 8'hef) + 8'h40);
      rd(2'b10, 3'h7, 8'h21, "ready_status");
      tx_fifo_ready <= 2'b10;
      rx_fifo_ready <= 2'b01;
      rd(2'b10, 3'h7, 8'h12, "ready_swapped");
      wr(2'b10, 3'h4, 8'h00);
      $display("test status done");
   endtask
   task automatic t_baud;
      int n;
      tx_fifo_ready <= 2'b11;
      tick_gap(3, "gap_div1");
      wr(2'b10, 3'h4, 8'h80);
      tick_gap(12, "gap_div4");
      wr(2'b10, 3'h4, 8'h00);
      tick_gap(3, "gap_back");
      check("tx_ready_idle", 16'h0000, {15'h0, transmit_ready_out_n[0]});
      wr(2'b10, 3'h0, 8'h5e);
      n = 0;
      while (tx_start[0] !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      check("tx_ready_at_start", 16'h0001, {15'h0, transmit_ready_out_n[0]});
      check("tx_start_early", 16'h0001, {15'h0, n >= 8 * 3 - 4});
      check("tx_start_late", 16'h0001, {15'h0, n <= 24 * 3});
      check("tx_data", 16'h005e, {8'h00, tx_data});
      $display("test baud done");
   endtask
   task automatic t_rx;
      rx_stop_done <= 2'b11;
      @(posedge clk_sys);
      rx_stop_done <= 2'b00;
      @(posedge clk_sys);
      check("rx_irq", 16'h0003, {14'h0, rx_irq});
      check("rx_ready_n", 16'h0000, {14'h0, receive_ready_out_n});
      rd(2'b10, 3'h0, 8'ha5, "rx_data_a");
      repeat (2) @(posedge clk_sys);
      check("rx_irq_clear", 16'h0002, {14'h0, rx_irq});
      check("rx_ready_clear", 16'h0001, {14'h0, receive_ready_out_n});
      $display("test receive done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      reset_n       = 1'b0;
      tx_fifo_ready = 2'b00;
      rx_fifo_ready = 2'b00;
      rx_stop_done  = 2'b00;
      rx_data       = 16'hb4a5;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_guard;
      t_banks;
      t_flow;
      t_status;
      t_baud;
      t_rx;
      print_verdict;
   end
   // the tests need a few hundred cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      print_verdict;
   end
endmodule
